// ===== hdl/legacy_region_decode_config.sv
// How it works
// R1 - Timer on: defer only after 31 stall clocks and a further address strobe.
// R2 - Timer off: defer as soon as another address strobe arrives.
// R3 - Close policy 1: precharge all banks on a page miss.
// R4 - Close policy 0: precharge only the missed bank.
// R5 - Upper D hole on: D8000h to end of D segment goes to hub.
// R6 - Upper D hole off: that region follows the D segment field.
// R7 - CD hole on: DC000h-DFFFFh to hub; off: follows D segment field.
// R8 - Four 64 KB segments C, D, E, F from fields 1:0, 3:2, 5:4, 7:6.
// R9 - Field 00 sends reads and writes to the hub.
// R10 - Field 01 reads from DRAM, writes go to hub.
// R11 - Field 10 writes to DRAM, reads go to hub.
// R12 - Field 11 sends reads and writes to DRAM.
// R13 - Video buffer ignores fields; graphics or hub outside management mode.
// R14 - Hub side cycles never reach the video buffer.
// R15 - Space lock makes the row population register read-only.
// R16 - Two DIMMs, four rows; DIMM 1 code in 7:4, DIMM 0 in 3:0.
// R17 - Each DIMM code decodes to a total size, 0 empty to F 256 MB.
// R18 - An enabled hole wins over the D segment field.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/100ps
module legacy_region_decode_config #(
    parameter logic [7:0] STALL_CLOCKS = legacy_decode_pkg::DEFER_STALL_CLOCKS
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire legacy_decode_pkg::host_cycle_t cyc,
    output legacy_decode_pkg::route_t route,
    input wire logic snoop_stall,
    input wire logic address_strobe,
    output logic defer,
    input wire logic page_miss,
    output logic precharge_all,
    output logic precharge_bank,
    output logic [legacy_decode_pkg::DIMM_MB_W-1:0] dimm0_mb,
    output logic [legacy_decode_pkg::DIMM_MB_W-1:0] dimm1_mb,
    output logic [legacy_decode_pkg::DIMM_MB_W:0] total_mb
);
    if (STALL_CLOCKS == 8'h00) begin : g_bad_stall
        $error("legacy_region_decode_config: STALL_CLOCKS must be nonzero");
    end

    logic [7:0] bridge_config_reg;
    logic [7:0] segment_attr_reg;
    logic [7:0] dimm_pop_reg;
    logic gfx_route_reg;
    logic smm_lock_reg;
    logic [7:0] rdata_reg;
    logic defer_timer;
    logic page_close_policy;
    logic upper_d_hole_enable;
    logic cd_hole_enable;

    assign defer_timer = bridge_config_reg[legacy_decode_pkg::DEFER_TIMER_BIT];
    assign page_close_policy = bridge_config_reg[legacy_decode_pkg::PAGE_CLOSE_BIT];
    assign upper_d_hole_enable = bridge_config_reg[legacy_decode_pkg::UPPER_D_HOLE_BIT];
    assign cd_hole_enable = bridge_config_reg[legacy_decode_pkg::CD_HOLE_BIT];

    // Register writes
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bridge_config_reg <= legacy_decode_pkg::BRIDGE_CONFIG_RST;
        end else if (reg_wr && reg_addr == legacy_decode_pkg::BRIDGE_CONFIG_OFS) begin
            bridge_config_reg <= (reg_wdata & legacy_decode_pkg::BRIDGE_CONFIG_WMASK)
                | (legacy_decode_pkg::BRIDGE_CONFIG_RST & ~legacy_decode_pkg::BRIDGE_CONFIG_WMASK);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            segment_attr_reg <= legacy_decode_pkg::SEGMENT_ATTR_RST;
        end else if (reg_wr && reg_addr == legacy_decode_pkg::SEGMENT_ATTR_OFS) begin
            segment_attr_reg <= reg_wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dimm_pop_reg <= legacy_decode_pkg::DIMM_POP_RST;
        end else if (reg_wr && reg_addr == legacy_decode_pkg::DIMM_POP_OFS
                     && !smm_lock_reg) begin // R15
            dimm_pop_reg <= reg_wdata;
        end
    end

    // Lock is write-once: only reset clears it
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            gfx_route_reg <= legacy_decode_pkg::SMM_CTRL_RST[legacy_decode_pkg::GFX_ROUTE_BIT];
            smm_lock_reg <= legacy_decode_pkg::SMM_CTRL_RST[legacy_decode_pkg::SMM_LOCK_BIT];
        end else if (reg_wr && reg_addr == legacy_decode_pkg::SMM_CTRL_OFS) begin
            gfx_route_reg <= reg_wdata[legacy_decode_pkg::GFX_ROUTE_BIT];
            smm_lock_reg <= smm_lock_reg | reg_wdata[legacy_decode_pkg::SMM_LOCK_BIT];
        end
    end

    // Read data stand only in the cycle after each read strobe cycle
    always_ff @(posedge sys_clk) begin
        if (rst || !reg_rd) begin
            rdata_reg <= 8'h00;
        end else begin
            case (reg_addr)
                legacy_decode_pkg::BRIDGE_CONFIG_OFS: rdata_reg <= bridge_config_reg;
                legacy_decode_pkg::SEGMENT_ATTR_OFS: rdata_reg <= segment_attr_reg;
                legacy_decode_pkg::DIMM_POP_OFS: rdata_reg <= dimm_pop_reg;
                legacy_decode_pkg::SMM_CTRL_OFS: begin
                    rdata_reg <= 8'h00;
                    rdata_reg[legacy_decode_pkg::GFX_ROUTE_BIT] <= gfx_route_reg;
                    rdata_reg[legacy_decode_pkg::SMM_LOCK_BIT] <= smm_lock_reg;
                end
                default: rdata_reg <= 8'h00;
            endcase
        end
    end

    assign reg_rdata = rdata_reg;

    // Deferral of a stalled processor cycle
    legacy_decode_pkg::defer_state_t defer_state_reg;
    legacy_decode_pkg::defer_state_t defer_state_next;
    logic [7:0] stall_cnt_reg;
    logic defer_reg;
    logic defer_next;
    logic stall_done;

    assign stall_done = (defer_state_reg == legacy_decode_pkg::DEFER_STALL)
        && (stall_cnt_reg >= STALL_CLOCKS);

    always_comb begin
        defer_next = 1'b0;
        defer_state_next = defer_state_reg;
        case (defer_state_reg)
            legacy_decode_pkg::DEFER_IDLE: begin
                if (snoop_stall && address_strobe && !defer_timer) begin
                    defer_next = 1'b1; // R2
                end else if (snoop_stall) begin
                    defer_state_next = legacy_decode_pkg::DEFER_STALL;
                end
            end
            legacy_decode_pkg::DEFER_STALL: begin
                if (!snoop_stall) begin
                    defer_state_next = legacy_decode_pkg::DEFER_IDLE;
                end else if (address_strobe && (!defer_timer || stall_done)) begin
                    defer_next = 1'b1; // R1 R2
                    defer_state_next = legacy_decode_pkg::DEFER_IDLE;
                end
            end
            default: defer_state_next = legacy_decode_pkg::DEFER_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            defer_state_reg <= legacy_decode_pkg::DEFER_IDLE;
            defer_reg <= 1'b0;
        end else begin
            defer_state_reg <= defer_state_next;
            defer_reg <= defer_next;
        end
    end

    // Counts clocks spent in snoop stall, saturating
    always_ff @(posedge sys_clk) begin
        if (rst || defer_state_next != legacy_decode_pkg::DEFER_STALL) begin
            stall_cnt_reg <= 8'h00;
        end else if (defer_state_reg == legacy_decode_pkg::DEFER_STALL
                     && stall_cnt_reg != 8'hFF) begin
            stall_cnt_reg <= stall_cnt_reg + 8'h01; // R1
        end
    end

    assign defer = defer_reg;

    // Page miss precharge choice
    logic precharge_all_reg;
    logic precharge_bank_reg;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            precharge_all_reg <= 1'b0;
            precharge_bank_reg <= 1'b0;
        end else begin
            precharge_all_reg <= page_miss && page_close_policy; // R3
            precharge_bank_reg <= page_miss && !page_close_policy; // R4
        end
    end

    assign precharge_all = precharge_all_reg;
    assign precharge_bank = precharge_bank_reg;

    // Legacy region routing
    logic [1:0] seg_field;
    legacy_decode_pkg::route_target_t target_next;
    legacy_decode_pkg::route_t route_reg;

    assign seg_field = segment_attr_reg[cyc.addr[17:16]*legacy_decode_pkg::SEG_FIELD_W +: 2]; // R8

    always_comb begin
        target_next = legacy_decode_pkg::TGT_DRAM;
        if (cyc.addr >= legacy_decode_pkg::VIDEO_BASE
            && cyc.addr <= legacy_decode_pkg::VIDEO_LAST) begin
            if (cyc.from_hub) begin
                target_next = legacy_decode_pkg::TGT_REJECT; // R14
            end else if (cyc.system_management_mode) begin
                target_next = legacy_decode_pkg::TGT_DRAM;
            end else if (gfx_route_reg) begin
                target_next = legacy_decode_pkg::TGT_GFX; // R13
            end else begin
                target_next = legacy_decode_pkg::TGT_HUB; // R13
            end
        end else if (cyc.addr >= legacy_decode_pkg::LEGACY_BASE
                     && cyc.addr <= legacy_decode_pkg::LEGACY_LAST) begin
            if (upper_d_hole_enable && cyc.addr >= legacy_decode_pkg::UPPER_D_HOLE_BASE
                && cyc.addr <= legacy_decode_pkg::D_SEG_LAST) begin
                target_next = legacy_decode_pkg::TGT_HUB; // R5 R18
            end else if (cd_hole_enable && cyc.addr >= legacy_decode_pkg::CD_HOLE_BASE
                         && cyc.addr <= legacy_decode_pkg::D_SEG_LAST) begin
                target_next = legacy_decode_pkg::TGT_HUB; // R7 R18
            end else begin
                // R6 R7: holes disabled fall through to the D field here
                case (seg_field)
                    legacy_decode_pkg::ATTR_OFF: target_next = legacy_decode_pkg::TGT_HUB; // R9
                    legacy_decode_pkg::ATTR_READ_DRAM: target_next = cyc.write // R10
                        ? legacy_decode_pkg::TGT_HUB : legacy_decode_pkg::TGT_DRAM;
                    legacy_decode_pkg::ATTR_WRITE_DRAM: target_next = cyc.write // R11
                        ? legacy_decode_pkg::TGT_DRAM : legacy_decode_pkg::TGT_HUB;
                    legacy_decode_pkg::ATTR_BOTH_DRAM: target_next = legacy_decode_pkg::TGT_DRAM; // R12
                    default: target_next = legacy_decode_pkg::TGT_HUB;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            route_reg.valid <= 1'b0;
            route_reg.target <= legacy_decode_pkg::TGT_DRAM;
        end else begin
            route_reg.valid <= cyc.valid;
            route_reg.target <= target_next;
        end
    end

    assign route = route_reg;

    // DIMM population sizes
    logic [legacy_decode_pkg::DIMM_MB_W-1:0] size_mb [legacy_decode_pkg::DIMM_COUNT];
    logic [legacy_decode_pkg::DIMM_MB_W-1:0] dimm0_mb_reg;
    logic [legacy_decode_pkg::DIMM_MB_W-1:0] dimm1_mb_reg;
    logic [legacy_decode_pkg::DIMM_MB_W:0] total_mb_reg;

    for (genvar d = 0; d < legacy_decode_pkg::DIMM_COUNT; d++) begin : g_dimm
        dimm_size_decode #(
            .CODE_W(legacy_decode_pkg::DIMM_CODE_W)
        ) u_decode (
            .code(dimm_pop_reg[d*legacy_decode_pkg::DIMM_CODE_W +: 4]), // R16
            .size_mb(size_mb[d])
        );
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dimm0_mb_reg <= 9'h000;
            dimm1_mb_reg <= 9'h000;
            total_mb_reg <= 10'h000;
        end else begin
            dimm0_mb_reg <= size_mb[0]; // R17
            dimm1_mb_reg <= size_mb[1];
            total_mb_reg <= {1'b0, size_mb[0]} + {1'b0, size_mb[1]};
        end
    end

    assign dimm0_mb = dimm0_mb_reg;
    assign dimm1_mb = dimm1_mb_reg;
    assign total_mb = total_mb_reg;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_locked_pop_write;
        smm_lock_reg && reg_wr && reg_addr == legacy_decode_pkg::DIMM_POP_OFS;
    endsequence

    sequence s_attr_write_then_read;
        reg_wr && reg_addr == legacy_decode_pkg::SEGMENT_ATTR_OFS
        ##1 reg_rd && reg_addr == legacy_decode_pkg::SEGMENT_ATTR_OFS;
    endsequence

    property p_defer_after_stall;
        defer_reg && $past(defer_timer) |-> $past(stall_cnt_reg) >= STALL_CLOCKS;
    endproperty
    a_defer_after_stall: assert property (p_defer_after_stall) // R1
        else $error("deferred before stall count reached");

    property p_defer_immediate;
        !defer_timer && snoop_stall && address_strobe |=> defer_reg;
    endproperty
    a_defer_immediate: assert property (p_defer_immediate) // R2
        else $error("no immediate defer with timer off");

    property p_precharge_policy;
        page_miss |=> (precharge_all_reg == $past(page_close_policy))
            && (precharge_bank_reg != precharge_all_reg);
    endproperty
    a_precharge_policy: assert property (p_precharge_policy) // R3
        else $error("wrong precharge kind for page miss");

    property p_upper_d_hole;
        upper_d_hole_enable && cyc.addr >= legacy_decode_pkg::UPPER_D_HOLE_BASE
        && cyc.addr <= legacy_decode_pkg::D_SEG_LAST
        |=> route_reg.target == legacy_decode_pkg::TGT_HUB;
    endproperty
    a_upper_d_hole: assert property (p_upper_d_hole) // R5
        else $error("upper D hole not sent to hub");

    property p_cd_hole;
        cd_hole_enable && cyc.addr >= legacy_decode_pkg::CD_HOLE_BASE
        && cyc.addr <= legacy_decode_pkg::D_SEG_LAST
        |=> route_reg.target == legacy_decode_pkg::TGT_HUB;
    endproperty
    a_cd_hole: assert property (p_cd_hole) // R7
        else $error("CD hole not sent to hub");

    property p_seg_c_read_only;
        segment_attr_reg[1:0] == legacy_decode_pkg::ATTR_READ_DRAM
        && cyc.addr[31:16] == 16'h000C
        |=> route_reg.target == ($past(cyc.write) ? legacy_decode_pkg::TGT_HUB
            : legacy_decode_pkg::TGT_DRAM);
    endproperty
    a_seg_c_read_only: assert property (p_seg_c_read_only) // R10
        else $error("read-only segment routed wrongly");

    property p_video_hub_reject;
        cyc.from_hub && cyc.addr[31:17] == 15'h0005
        |=> route_reg.target == legacy_decode_pkg::TGT_REJECT;
    endproperty
    a_video_hub_reject: assert property (p_video_hub_reject) // R14
        else $error("hub cycle reached video buffer");

    property p_video_route;
        !cyc.from_hub && !cyc.system_management_mode && cyc.addr[31:17] == 15'h0005
        |=> route_reg.target == ($past(gfx_route_reg) ? legacy_decode_pkg::TGT_GFX
            : legacy_decode_pkg::TGT_HUB);
    endproperty
    a_video_route: assert property (p_video_route) // R13
        else $error("video buffer routed wrongly");

    property p_pop_locked;
        s_locked_pop_write |=> $stable(dimm_pop_reg);
    endproperty
    a_pop_locked: assert property (p_pop_locked) // R15
        else $error("population changed while locked");

    property p_attr_readback;
        s_attr_write_then_read |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    a_attr_readback: assert property (p_attr_readback) // R8
        else $error("attribute readback mismatch");

endmodule

// ===== hdl/legacy_decode_pkg.sv
package legacy_decode_pkg;

    // Register offsets
    localparam logic [7:0] BRIDGE_CONFIG_OFS = 8'h50;
    localparam logic [7:0] SEGMENT_ATTR_OFS = 8'h51;
    localparam logic [7:0] DIMM_POP_OFS = 8'h52;
    localparam logic [7:0] SMM_CTRL_OFS = 8'h70;

    // Reset values
    localparam logic [7:0] BRIDGE_CONFIG_RST = 8'h60;
    localparam logic [7:0] SEGMENT_ATTR_RST = 8'h00;
    localparam logic [7:0] DIMM_POP_RST = 8'h00;
    localparam logic [7:0] SMM_CTRL_RST = 8'h00;

    // Writable bits of bridge_config; the rest hold their reset value
    localparam logic [7:0] BRIDGE_CONFIG_WMASK = 8'h4B;

    // Field positions
    localparam int CD_HOLE_BIT = 0;
    localparam int UPPER_D_HOLE_BIT = 1;
    localparam int PAGE_CLOSE_BIT = 3;
    localparam int DEFER_TIMER_BIT = 6;
    localparam int GFX_ROUTE_BIT = 0;
    localparam int SMM_LOCK_BIT = 4;
    localparam int SEG_FIELD_W = 2;
    localparam int DIMM_CODE_W = 4;
    localparam int DIMM_COUNT = 2;
    localparam int DIMM_MB_W = 9;
    localparam int SEG_D_LSB = 2;

    // Legacy address map
    localparam logic [31:0] VIDEO_BASE = 32'h000A0000;
    localparam logic [31:0] VIDEO_LAST = 32'h000BFFFF;
    localparam logic [31:0] LEGACY_BASE = 32'h000C0000;
    localparam logic [31:0] LEGACY_LAST = 32'h000FFFFF;
    localparam logic [31:0] UPPER_D_HOLE_BASE = 32'h000D8000;
    localparam logic [31:0] CD_HOLE_BASE = 32'h000DC000;
    localparam logic [31:0] D_SEG_LAST = 32'h000DFFFF;

    // Segment attribute encodings
    localparam logic [1:0] ATTR_OFF = 2'h0;
    localparam logic [1:0] ATTR_READ_DRAM = 2'h1;
    localparam logic [1:0] ATTR_WRITE_DRAM = 2'h2;
    localparam logic [1:0] ATTR_BOTH_DRAM = 2'h3;

    // Snoop stall length before a deferral in timer mode
    localparam logic [7:0] DEFER_STALL_CLOCKS = 8'h1F;

    typedef enum logic [1:0] {
        TGT_DRAM = 2'b00,
        TGT_HUB = 2'b01,
        TGT_GFX = 2'b10,
        TGT_REJECT = 2'b11
    } route_target_t;

    typedef enum logic {
        DEFER_IDLE = 1'b0,
        DEFER_STALL = 1'b1
    } defer_state_t;

    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic write;
        logic from_hub;
        logic system_management_mode;
    } host_cycle_t;

    typedef struct packed {
        logic valid;
        route_target_t target;
    } route_t;

endpackage

// ===== hdl/dimm_size_decode.sv
`timescale 1ns/100ps
module dimm_size_decode #(
    parameter int CODE_W = 4
) (
    input wire logic [CODE_W-1:0] code,
    output logic [legacy_decode_pkg::DIMM_MB_W-1:0] size_mb
);
    if (CODE_W != legacy_decode_pkg::DIMM_CODE_W) begin : g_bad_width
        $error("dimm_size_decode: CODE_W must be 4");
    end

    // Total megabytes per population code; unlisted codes count as empty
    always_comb begin
        case (code)
            4'h1: size_mb = 9'h008; // R17
            4'h3: size_mb = 9'h010;
            4'h4: size_mb = 9'h010;
            4'h5: size_mb = 9'h018;
            4'h6: size_mb = 9'h020;
            4'h7: size_mb = 9'h020;
            4'h8: size_mb = 9'h030;
            4'h9: size_mb = 9'h040;
            4'hA: size_mb = 9'h040;
            4'hB: size_mb = 9'h060;
            4'hC: size_mb = 9'h080;
            4'hD: size_mb = 9'h080;
            4'hE: size_mb = 9'h0C0;
            4'hF: size_mb = 9'h100; // R17
            default: size_mb = 9'h000;
        endcase
    end
endmodule

// ===== testbench/fsb_model.sv
`timescale 1ns/100ps
module fsb_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [7:0] len,
    output logic snoop_stall,
    output logic address_strobe
);
    logic [7:0] left_reg;

    // Holds a cycle in snoop stall for len clocks, strobing on the last
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            left_reg <= 8'h00;
            snoop_stall <= 1'h0;
            address_strobe <= 1'h0;
        end else if (start) begin
            left_reg <= len;
            snoop_stall <= 1'h1;
            address_strobe <= (len == 8'h01);
        end else if (left_reg > 8'h01) begin
            left_reg <= left_reg - 8'h01;
            address_strobe <= (left_reg == 8'h02);
        end else begin
            left_reg <= 8'h00;
            snoop_stall <= 1'h0;
            address_strobe <= 1'h0;
        end
    end
endmodule

// ===== testbench/tb.sv
`timescale 1ns/100ps
module tb;
    localparam logic [7:0] STALL = 8'h04;
    localparam int MB[16] = '{0, 8, 0, 16, 16, 24, 32, 32, 48, 64, 64, 96, 128, 128, 192, 256};
    logic sys_clk = 1'h0;
    logic rst = 1'h1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic [7:0] reg_rdata;
    legacy_decode_pkg::host_cycle_t cyc = '0;
    legacy_decode_pkg::route_t route;
    logic snoop_stall, address_strobe, defer, precharge_all, precharge_bank;
    logic page_miss = 1'h0;
    logic [8:0] dimm0_mb, dimm1_mb;
    logic [9:0] total_mb;
    logic start = 1'h0;
    logic [7:0] len = 8'h00;
    logic [7:0] cfg = 8'h60;
    logic [7:0] attr = 8'h00;
    logic [7:0] smm_ctl = 8'h00;
    logic rd_seen = 1'h0;
    int fails = 0;
    int num_checks = 0;
    int run = 0;
    int seed = 32'hd8e5;
    logic [9:0] rq[$], tq[$], dq[$], pq[$];

    legacy_region_decode_config #(.STALL_CLOCKS(STALL)) dut_u (
        .sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cyc, .route,
        .snoop_stall, .address_strobe, .defer, .page_miss, .precharge_all, .precharge_bank,
        .dimm0_mb, .dimm1_mb, .total_mb);

    fsb_model fsb_u (.sys_clk, .rst, .start, .len, .snoop_stall, .address_strobe);

    initial begin
        forever #50 sys_clk = ~sys_clk;
    end

    task chk(input string n, input logic [9:0] e, input logic [9:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    task chk_rdata(input logic [9:0] e, input logic [9:0] g);
        chk("reg_rdata", e, g);
    endtask

    task chk_route(input logic [9:0] e, input logic [9:0] g);
        chk("route", e, g);
    endtask

    task chk_defer(input logic [9:0] e, input logic [9:0] g);
        chk("defer", e, g);
    endtask

    task chk_precharge(input logic [9:0] e, input logic [9:0] g);
        chk("precharge", e, g);
    endtask

    task chk_size(input string n, input logic [9:0] e, input logic [9:0] g);
        chk(n, e, g);
    endtask

    task test_done;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge sys_clk);
        reg_wr <= 1'h0;
    endtask

    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        rq.push_back({2'h0, e});
        @(posedge sys_clk);
        reg_rd <= 1'h0;
    endtask

    // Write then read back with no gap between the strobes
    task wr_rd(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge sys_clk);
        reg_wr <= 1'h0;
        reg_rd <= 1'h1;
        rq.push_back({2'h0, d});
        @(posedge sys_clk);
        reg_rd <= 1'h0;
    endtask

    task setcfg(input logic [7:0] d);
        cfg = (d & legacy_decode_pkg::BRIDGE_CONFIG_WMASK)
            | (cfg & ~legacy_decode_pkg::BRIDGE_CONFIG_WMASK);
        wr(8'h50, d);
        rd(8'h50, cfg);
    endtask

    task run_fsb(input logic [7:0] n);
        @(posedge sys_clk);
        start <= 1'h1;
        len <= n;
        @(posedge sys_clk);
        start <= 1'h0;
        repeat (n + 2) @(posedge sys_clk);
    endtask

    // Targets: 0 DRAM, 1 hub, 2 graphics, 3 refused
    function automatic logic [9:0] tgt(input logic [31:0] a, input logic w, h, s);
        logic [1:0] f;
        f = 2'(attr >> {a[17:16], 1'h0});
        if (a >= legacy_decode_pkg::VIDEO_BASE && a <= legacy_decode_pkg::VIDEO_LAST)
            return h ? 10'h3 : s ? 10'h0 : smm_ctl[0] ? 10'h2 : 10'h1;
        if (a < legacy_decode_pkg::LEGACY_BASE || a > legacy_decode_pkg::LEGACY_LAST)
            return 10'h0;
        if (a <= legacy_decode_pkg::D_SEG_LAST) begin
            if (cfg[1] && a >= legacy_decode_pkg::UPPER_D_HOLE_BASE)
                return 10'h1;
            if (cfg[0] && a >= legacy_decode_pkg::CD_HOLE_BASE)
                return 10'h1;
        end
        return (w ? f[1] : f[0]) ? 10'h0 : 10'h1;
    endfunction

    // Output watcher: settled values are compared at the falling edge
    always @(negedge sys_clk) begin
        logic [9:0] e;
        if (rd_seen) chk_rdata(rq.pop_front(), 10'(reg_rdata));
        rd_seen = reg_rd;
        if (route.valid === 1'h1) chk_route(tq.pop_front(), 10'(route.target));
        e = dq.size() ? dq.pop_front() : 10'h000;
        chk_defer(e, 10'(defer));
        e = pq.size() ? pq.pop_front() : 10'h000;
        chk_precharge(e, {8'h00, precharge_all, precharge_bank});
        run = snoop_stall ? run + 1 : 0;
        if (snoop_stall && address_strobe)
            dq.push_back(10'(!cfg[6] || run >= STALL + 2));
        if (page_miss)
            pq.push_back({8'h00, cfg[3], !cfg[3]});
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        test_done;
    end

    initial begin
        logic [31:0] a;
        legacy_decode_pkg::host_cycle_t c;
        logic [7:0] d;
        repeat (2) @(posedge sys_clk);
        rst <= 1'h0;
        rd(8'h50, 8'h60);
        rd(8'h51, 8'h00);
        rd(8'h52, 8'h00);
        rd(8'h70, 8'h00);
        wr(8'h53, 8'hFF);
        rd(8'h53, 8'h00);
        for (int j = 0; j < 16; j++) begin
            d = 8'($random(seed));
            d[1:0] = j[3:2];
            setcfg(d);
            attr = 8'($random(seed));
            attr[3:2] = j[1:0];
            wr_rd(8'h51, attr);
            smm_ctl[0] = j[0] ^ j[3];
            wr(8'h70, smm_ctl);
            for (int k = 0; k < 24; k++) begin
                a = k[0] ? 32'h000D0000 + ({$random(seed)} % 32'h10000)
                    : 32'h00098000 + ({$random(seed)} % 32'h70000);
                c = {1'h1, a, 3'($random(seed))};
                @(posedge sys_clk);
                cyc <= c;
                tq.push_back(tgt(c.addr, c.write, c.from_hub, c.system_management_mode));
            end
            @(posedge sys_clk);
            cyc <= '0;
        end
        setcfg(8'h00);
        run_fsb(8'h01);
        run_fsb(8'h03);
        setcfg(8'h40);
        run_fsb(8'h05);
        run_fsb(8'h06);
        run_fsb(8'h09);
        for (int p = 0; p < 2; p++) begin
            setcfg(p ? 8'h08 : 8'h00);
            @(posedge sys_clk);
            page_miss <= 1'h1;
            @(posedge sys_clk);
            page_miss <= 1'h0;
            repeat (2) @(posedge sys_clk);
        end
        for (int i = 0; i < 16; i++) begin
            wr(8'h52, {i[3:0], ~i[3:0]});
            repeat (3) @(posedge sys_clk);
            @(negedge sys_clk);
            chk_size("dimm1_mb", 10'(MB[i]), 10'(dimm1_mb));
            chk_size("dimm0_mb", 10'(MB[15 - i]), 10'(dimm0_mb));
            chk_size("total_mb", 10'(MB[i] + MB[15 - i]), total_mb);
        end
        wr(8'h70, 8'h10);
        wr(8'h52, 8'h33);
        rd(8'h52, 8'hF0);
        wr(8'h70, 8'h00);
        rd(8'h70, 8'h10);
        @(posedge sys_clk);
        rst <= 1'h1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'h0;
        cfg = 8'h60;
        rd(8'h70, 8'h00);
        rd(8'h52, 8'h00);
        rd(8'h50, 8'h60);
        repeat (4) @(posedge sys_clk);
        // Every noted result must have been seen
        chk("pending", 10'h000, 10'(rq.size() + tq.size() + dq.size() + pq.size()));
        test_done;
    end
endmodule
